/* File: rtl/slmc_config.sv */
// Link mode configuration, checking and upsampling datapath for the receive side
`timescale 1ns/1ps
module slmc_config
  import slmc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [15:0] sampleIn,
  input  wire logic        sampleValid,
  output logic      [15:0] sampleOut,
  output logic             sampleOutValid,
  output logic      [7:0]  laneEnable,
  output logic      [7:0]  lane_powerdown_mask,
  output logic      [1:0]  linksEnabled,
  output logic             configError
);

  // ----------------------------------------------------------------
  // Mode table
  // ----------------------------------------------------------------
  function automatic slmc_mode_t modeLookup(input logic [3:0] id);
    slmc_mode_t e;
    e = '0;
    unique case (id)
      4'h8: e = '{1'b1, 1'b1, 1'b0, 4'd4, 2'd2, 2'd1, 8'h0f};
      4'h9: e = '{1'b1, 1'b1, 1'b0, 4'd2, 2'd1, 2'd1, 8'h03};
      4'ha: e = '{1'b1, 1'b1, 1'b1, 4'd1, 2'd1, 2'd2, 8'h01};
      4'hb: e = '{1'b1, 1'b0, 1'b0, 4'd4, 2'd2, 2'd1, 8'hff};
      4'hc: e = '{1'b1, 1'b0, 1'b0, 4'd2, 2'd1, 2'd1, 8'h33};
      4'hd: e = '{1'b1, 1'b0, 1'b1, 4'd1, 2'd1, 2'd2, 8'h11};
      default: e = '0;
    endcase
    return e;
  endfunction : modeLookup

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [31:0] ctrl;
  logic [31:0] frame;
  logic [31:0] linkRegs;   // Link 1 shadow: set identical to link 0 on write
  logic [1:0]  stickyErr;

  wire        busReq   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire        busWrite = busReq & wb_we_i;
  wire        hitCtrl  = wb_adr_i == REG_CTRL;
  wire        hitFrame = wb_adr_i == REG_FRAME;
  wire [31:0] byteMask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}},
                          {8{wb_sel_i[0]}}};
  wire        linkOn   = ctrl[CTRL_LINK_EN];
  // Upsampling is frozen while the link is up; write attempts are dropped
  wire [31:0] ctrlMask = linkOn ? (byteMask & ~32'h0000_0007) : byteMask;
  wire [31:0] next_ctrl  = (ctrl & ~ctrlMask) | (wb_dat_i & ctrlMask);
  wire [31:0] next_frame = (frame & ~byteMask) | (wb_dat_i & byteMask);

  // ----------------------------------------------------------------
  // Decoded configuration and checks
  // ----------------------------------------------------------------
  wire [2:0]  upsample_select = ctrl[CTRL_UPS_LSB +: 3];
  wire [3:0]  modeId          = ctrl[CTRL_MODE_LSB +: 4];
  wire        two_link_select = ctrl[CTRL_TWO_LINK];
  wire        link_view_select = ctrl[CTRL_VIEW];
  wire        config_sum_method = ctrl[CTRL_SUM_METH];
  wire [7:0]  kMinus1  = frame[FRM_K_LSB +: 8];
  wire [7:0]  nMinus1  = frame[FRM_N_LSB +: 8];
  wire [7:0]  npMinus1 = frame[FRM_NP_LSB +: 8];
  wire        hdBit    = frame[FRM_HD];
  slmc_mode_t mode;
  assign mode = modeLookup(modeId);

  wire upsLegal  = (upsample_select == UPS_X1) | (upsample_select == UPS_X2) |
                   (upsample_select == UPS_X4) | (upsample_select == UPS_X8);
  wire errMode   = ~mode.valid;
  wire errUps    = ~upsLegal | ((modeId == MODE_FIRST) & (upsample_select != UPS_X1));
  wire errLink   = two_link_select & ~mode.twoLinkOk;
  wire errHd     = hdBit != (mode.octets == 2'd1);
  wire errN      = (nMinus1 != N_REQ - 8'd1) | (npMinus1 != N_REQ - 8'd1);
  wire errK      = ~((kMinus1 == K_LONG - 8'd1) |
                     (mode.kShortOk & (kMinus1 == K_SHORT - 8'd1)));
  wire anyErr    = errMode | errUps | errLink | errHd | errN | errK;

  // Field-sum checksum: L-1, M-1(=0), K-1, N-1, NP-1, S-1, scr, HD, subclass, ver
  wire [7:0] fieldSum = 8'(mode.lanes - 4'd1) + kMinus1 + nMinus1 + npMinus1 +
                        8'(mode.samples - 2'd1) + 8'(ctrl[CTRL_SCRAMBLE]) + 8'(hdBit) +
                        8'(ctrl[CTRL_SUBCLASS]) + 8'(frame[FRM_VER_LSB +: 3]);
  // Register-sum method: sum of the four bytes of the frame word and the low three bytes of the control word
  wire [7:0] regSum   = frame[7:0] + frame[15:8] + frame[23:16] + frame[31:24] +
                        ctrl[7:0] + ctrl[15:8] + ctrl[23:16];
  wire [7:0] first_lane_config_sum = config_sum_method ? regSum : fieldSum;

  wire [1:0] next_links = ~linkOn ? 2'b00 : (two_link_select ? 2'b11 : 2'b01);

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl     <= CTRL_RST;
      frame    <= FRAME_RST;
      linkRegs <= FRAME_RST;
    end else if (busWrite && hitCtrl) begin
      ctrl <= next_ctrl;
    end else if (busWrite && hitFrame) begin
      frame    <= next_frame;
      linkRegs <= next_frame; // Both links always hold the same parameters
    end
  end

  // Errors latch; a new error in the clearing cycle wins over the clear
  wire       errClear = busWrite & (wb_adr_i == REG_STATUS) & wb_sel_i[0];
  wire [1:0] next_sticky = ({errUps, anyErr}) |
                           (stickyErr & ~(errClear ? wb_dat_i[1:0] : 2'b00));
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) stickyErr <= 2'b00;
    else         stickyErr <= next_sticky;
  end

  // ----------------------------------------------------------------
  // Wishbone answer: one wait state, unmapped reads return zero
  // ----------------------------------------------------------------
  wire [31:0] statusWord = {16'h0000, first_lane_config_sum, 4'h0, link_view_select,
                            anyErr, stickyErr};
  wire [31:0] derivWord  = {8'h00, mode.laneMask, 4'h0, mode.lanes, 6'h00, mode.samples};
  wire [31:0] viewFrame  = link_view_select ? linkRegs : frame;
  wire [31:0] next_rdata =
    (wb_adr_i == REG_CTRL)   ? ctrl :
    (wb_adr_i == REG_LINK)   ? {30'h0, linksEnabled} :
    (wb_adr_i == REG_FRAME)  ? viewFrame :
    (wb_adr_i == REG_STATUS) ? statusWord :
    (wb_adr_i == REG_DERIV)  ? derivWord :
    (wb_adr_i == REG_SUM)    ? {24'h0, first_lane_config_sum} : 32'h0;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= busReq;
      wb_dat_o <= busReq ? next_rdata : 32'h0;
    end
  end

  // ----------------------------------------------------------------
  // Lane outputs
  // ----------------------------------------------------------------
  wire [7:0] next_laneEn = (linkOn & ~anyErr) ? mode.laneMask : 8'h00;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      laneEnable          <= 8'h00;
      lane_powerdown_mask <= 8'hff;
      linksEnabled        <= 2'b00;
      configError         <= 1'b0;
    end else begin
      laneEnable          <= next_laneEn;
      lane_powerdown_mask <= ~next_laneEn;
      linksEnabled        <= next_links;
      configError         <= anyErr;
    end
  end

  // ----------------------------------------------------------------
  // Upsampling chain: each stage doubles rate (zero-stuff + averaging low-pass)
  // Short averaging filter trades stopband depth for area
  // ----------------------------------------------------------------
  wire [1:0] stageCount = (upsample_select == UPS_X2) ? 2'd1 :
                          (upsample_select == UPS_X4) ? 2'd2 :
                          (upsample_select == UPS_X8) ? 2'd3 : 2'd0;
  logic [15:0] stData  [0:3];
  logic        stValid [0:3];
  logic [15:0] stHold  [1:3];
  logic [2:0]  stWait  [1:3];
  assign stData[0]  = sampleIn;
  assign stValid[0] = sampleValid;

  for (genvar g = 1; g < 4; g++) begin : g_stage
    wire [16:0] avgSum = {stHold[g][15], stHold[g]} + {stData[g-1][15], stData[g-1]};
    // Second output is spaced so a following selected stage never sees two inputs back to back
    wire [1:0]  gapExp = stageCount - 2'(g);
    wire [2:0]  gapLen = (2'(g) > stageCount) ? 3'd1 : (3'd1 << gapExp);
    always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
        stHold[g]  <= 16'h0;
        stWait[g]  <= 3'd0;
        stData[g]  <= 16'h0;
        stValid[g] <= 1'b0;
      end else if (stValid[g-1]) begin
        stHold[g]  <= stData[g-1];
        stData[g]  <= avgSum[16:1];
        stValid[g] <= 1'b1;
        stWait[g]  <= gapLen;
      end else if (stWait[g] == 3'd1) begin
        stData[g]  <= stHold[g];
        stValid[g] <= 1'b1;
        stWait[g]  <= 3'd0;
      end else begin
        stValid[g] <= 1'b0;
        if (stWait[g] != 3'd0) stWait[g] <= stWait[g] - 3'd1;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sampleOut      <= 16'h0;
      sampleOutValid <= 1'b0;
    end else begin
      sampleOut      <= stData[stageCount];
      sampleOutValid <= stValid[stageCount] & linkOn;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_mode8_bypass: assert property (@(posedge clk) disable iff (sys_rst)
    (modeId == MODE_FIRST && upsample_select != UPS_X1) |=> configError)
    else $error("mode 8 with upsampling not flagged");
  a_hd_check: assert property (@(posedge clk) disable iff (sys_rst)
    (mode.valid && hdBit != (mode.octets == 2'd1)) |=> configError)
    else $error("HD mismatch not flagged");
  a_n_sixteen: assert property (@(posedge clk) disable iff (sys_rst)
    (nMinus1 != 8'd15) |=> configError)
    else $error("N not sixteen but no error");
  a_k_long: assert property (@(posedge clk) disable iff (sys_rst)
    (modeId == 4'h9 && kMinus1 == 8'd15) |=> configError)
    else $error("K of 16 accepted in mode 9");
  a_lane_mask: assert property (@(posedge clk) disable iff (sys_rst)
    (modeId == 4'hc && linkOn && !anyErr) |=> laneEnable == 8'h33)
    else $error("wrong lane mask for mode 12");
  a_single_only: assert property (@(posedge clk) disable iff (sys_rst)
    (modeId == 4'hb && two_link_select) |=> configError)
    else $error("dual link accepted in mode 11");
  a_links_same: assert property (@(posedge clk) disable iff (sys_rst)
    $changed(frame) |-> linkRegs == frame)
    else $error("link parameter copies differ");
  a_ups_frozen: assert property (@(posedge clk) disable iff (sys_rst)
    ($past(linkOn) && linkOn) |-> $stable(upsample_select))
    else $error("upsample changed while link up");
  a_err_sticky: assert property (@(posedge clk) disable iff (sys_rst)
    anyErr |=> stickyErr[0])
    else $error("error not latched");

endmodule : slmc_config

/* File: rtl/slmc_pkg.sv */
// Package: register map, field positions, mode table entry type and encodings
package slmc_pkg;
  // Register byte offsets
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_LINK   = 8'h04;
  localparam logic [7:0] REG_FRAME  = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_DERIV  = 8'h10;
  localparam logic [7:0] REG_SUM    = 8'h14;
  // CTRL fields
  localparam int CTRL_UPS_LSB  = 0;   // upsample_select [2:0]
  localparam int CTRL_MODE_LSB = 8;   // mode id [3:0]
  localparam int CTRL_TWO_LINK = 12;  // two_link_select
  localparam int CTRL_VIEW     = 13;  // link_view_select
  localparam int CTRL_SUM_METH = 14;  // config_sum_method
  localparam int CTRL_SCRAMBLE = 15;
  localparam int CTRL_SUBCLASS = 16;
  localparam int CTRL_LINK_EN  = 17;
  // FRAME fields: K-1, N-1, NP-1, HD, jesd version
  localparam int FRM_K_LSB   = 0;
  localparam int FRM_N_LSB   = 8;
  localparam int FRM_NP_LSB  = 16;
  localparam int FRM_HD      = 24;
  localparam int FRM_VER_LSB = 25;
  // Reset values
  localparam logic [31:0] CTRL_RST  = 32'h0000_0a00;
  // Default mode uses two octets per frame, so high density must start cleared
  localparam logic [31:0] FRAME_RST = 32'h020f_0f1f;
  // Upsample encodings
  localparam logic [2:0] UPS_X1 = 3'h0;
  localparam logic [2:0] UPS_X2 = 3'h1;
  localparam logic [2:0] UPS_X4 = 3'h3;
  localparam logic [2:0] UPS_X8 = 3'h4;
  localparam logic [7:0] N_REQ    = 8'h10;
  localparam logic [7:0] K_LONG   = 8'h20;
  localparam logic [7:0] K_SHORT  = 8'h10;
  // Mode table entries packed as {valid, twoLinkOk, kShortOk, L, S, F, lane mask}
  typedef struct packed {
    logic       valid;
    logic       twoLinkOk;
    logic       kShortOk;
    logic [3:0] lanes;
    logic [1:0] samples;
    logic [1:0] octets;
    logic [7:0] laneMask;
  } slmc_mode_t;
  localparam logic [3:0] MODE_FIRST = 4'h8;
  localparam logic [3:0] MODE_LAST  = 4'hd;
endpackage : slmc_pkg

/* File: verif/slmc_config_bench.sv */
// Self-checking bench for the link mode configuration block
`timescale 1ns/1ps
module slmc_config_bench;
  import slmc_pkg::*;
  logic        clk, sys_rst, cyc, stb, we, wbAck, outValid, txStart, txBusy, configError;
  logic [7:0]  adr, laneEnable, lane_powerdown_mask;
  logic [31:0] dat, rdat;
  logic [15:0] sampleIn, sampleOut, txValue, lastOut;
  logic        sampleValid;
  logic [1:0]  linksEnabled;
  int          errors, checkCount, outCount;
  localparam logic [7:0] MASK [6] = '{8'h0f, 8'h03, 8'h01, 8'hff, 8'h33, 8'h11};
  localparam logic [3:0] RXL [6] = '{4'h4, 4'h2, 4'h1, 4'h4, 4'h2, 4'h1};
  localparam logic [1:0] SMP [6] = '{2'h2, 2'h1, 2'h1, 2'h2, 2'h1, 2'h1};
  localparam logic       HDV [6] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
  slmc_config u_dut (.clk(clk), .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(rdat),
    .wb_ack_o(wbAck), .sampleIn(sampleIn), .sampleValid(sampleValid),
    .sampleOut(sampleOut), .sampleOutValid(outValid), .laneEnable(laneEnable),
    .lane_powerdown_mask(lane_powerdown_mask), .linksEnabled(linksEnabled),
    .configError(configError));
  slmc_tx_model u_tx (.clk(clk), .sys_rst(sys_rst), .start(txStart), .value(txValue),
    .sampleIn(sampleIn), .sampleValid(sampleValid), .busy(txBusy));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    if (outValid === 1'b1) begin
      outCount <= outCount + 1;
      lastOut  <= sampleOut;
    end
  end
  // ----------------------------------------
  // Bus and compare tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checkCount++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wbAck !== 1'b1 && n < 20);
    if (n >= 20) chk(32'h0, 32'h1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task automatic cfg(input logic [3:0] m, input logic [2:0] u, input logic two,
                     input logic hd, input logic [7:0] k, input logic [7:0] n, input logic s);
    logic [31:0] q;
    logic [31:0] c;
    c = {14'h0, 3'h0, s, 1'b0, two, m, 5'h0, u};
    // Link dropped before upsampling changes, then raised again
    wb(1'b1, REG_CTRL, c, q);
    wb(1'b1, REG_CTRL, c, q);
    wb(1'b1, REG_FRAME, {4'h0, 3'h1, hd, n, n, k}, q);
    c[CTRL_LINK_EN] = 1'b1;
    wb(1'b1, REG_CTRL, c, q);
    repeat (3) @(posedge clk);
  endtask : cfg
  task automatic bad(input logic [3:0] m, input logic [2:0] u, input logic two,
                     input logic hd, input logic [7:0] k, input logic [7:0] n, input logic e);
    cfg(m, u, two, hd, k, n, 1'b0);
    chk({31'h0, configError}, {31'h0, e});
    if (e) chk({24'h0, laneEnable}, 32'h0);
    else chk({30'h0, linksEnabled}, {30'h0, two, 1'b1});
  endtask : bad
  task automatic endOfTest();
    if (errors == 0 && checkCount > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : endOfTest
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    logic [31:0] q;
    wb(1'b0, REG_CTRL, 32'h0, q);
    chk(q, CTRL_RST);
    wb(1'b0, REG_FRAME, 32'h0, q);
    chk(q, FRAME_RST);
    chk({16'h0, laneEnable, lane_powerdown_mask}, 32'h00ff);
  endtask : t_reset
  task automatic t_modes();
    logic [31:0] q;
    for (int i = 0; i < 6; i++) begin
      cfg(4'(i + 8), UPS_X1, 1'b0, HDV[i], 8'h1f, 8'h0f, 1'b0);
      chk({31'h0, configError}, 32'h0);
      chk({16'h0, laneEnable, lane_powerdown_mask}, {16'h0, MASK[i], ~MASK[i]});
      wb(1'b0, REG_DERIV, 32'h0, q);
      chk(q, {8'h0, MASK[i], 4'h0, RXL[i], 6'h0, SMP[i]});
    end
  endtask : t_modes
  task automatic t_ups();
    logic [2:0] codes [4];
    int         n;
    codes = '{UPS_X1, UPS_X2, UPS_X4, UPS_X8};
    for (int i = 0; i < 4; i++) begin
      cfg(4'h9, codes[i], 1'b0, 1'b1, 8'h1f, 8'h0f, 1'b0);
      outCount = 0;
      txStart <= 1'b1;
      txValue <= 16'h1230 + 16'(i);
      repeat (2) @(posedge clk);
      txStart <= 1'b0;
      n = 0;
      while (txBusy === 1'b1 && n < 200) begin
        @(posedge clk);
        n++;
      end
      repeat (12) @(posedge clk);
      chk(outCount, 32'd3 << i);
      chk({16'h0, lastOut}, {16'h0, txValue});
    end
  endtask : t_ups
  task automatic t_regs();
    logic [31:0] q;
    wb(1'b1, REG_CTRL, 32'h0002_0900, q);
    wb(1'b0, REG_CTRL, 32'h0, q);
    chk({29'h0, q[2:0]}, {29'h0, UPS_X8});
    wb(1'b1, 8'h3c, 32'hffff_ffff, q);
    wb(1'b0, 8'h3c, 32'h0, q);
    chk(q, 32'h0);
    wb(1'b0, REG_LINK, 32'h0, q);
    chk(q, 32'h1);
    cfg(4'h9, UPS_X1, 1'b0, 1'b1, 8'h1f, 8'h0f, 1'b0);
    wb(1'b0, REG_SUM, 32'h0, q);
    chk({24'h0, q[7:0]}, 32'h40);
    cfg(4'h9, UPS_X1, 1'b0, 1'b1, 8'h1f, 8'h0f, 1'b1);
    wb(1'b0, REG_SUM, 32'h0, q);
    chk({24'h0, q[7:0]}, 32'h8b);
    wb(1'b0, REG_STATUS, 32'h0, q);
    chk({30'h0, q[1:0]}, 32'h3);
    wb(1'b1, REG_STATUS, 32'h3, q);
    wb(1'b0, REG_STATUS, 32'h0, q);
    chk({30'h0, q[1:0]}, 32'h0);
  endtask : t_regs
  task automatic t_errors();
    bad(4'h8, UPS_X2, 1'b0, 1'b1, 8'h1f, 8'h0f, 1'b1);
    bad(4'h8, UPS_X1, 1'b1, 1'b1, 8'h1f, 8'h0f, 1'b0);
    bad(4'hb, UPS_X1, 1'b1, 1'b1, 8'h1f, 8'h0f, 1'b1);
    bad(4'h9, UPS_X1, 1'b0, 1'b0, 8'h1f, 8'h0f, 1'b1);
    bad(4'ha, UPS_X1, 1'b0, 1'b1, 8'h1f, 8'h0f, 1'b1);
    bad(4'h9, UPS_X1, 1'b0, 1'b1, 8'h0f, 8'h0f, 1'b1);
    bad(4'hd, UPS_X1, 1'b0, 1'b0, 8'h0f, 8'h0f, 1'b0);
    bad(4'hc, UPS_X1, 1'b0, 1'b1, 8'h1f, 8'h0b, 1'b1);
    bad(4'h9, 3'h2, 1'b0, 1'b1, 8'h1f, 8'h0f, 1'b1);
    bad(4'h7, UPS_X1, 1'b0, 1'b1, 8'h1f, 8'h0f, 1'b1);
  endtask : t_errors
  initial begin
    {sys_rst, cyc, stb, we, txStart} = 5'b10000;
    {adr, dat, txValue, errors, checkCount, outCount} = '0;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset();
    t_modes();
    t_errors();
    t_ups();
    t_regs();
    endOfTest();
  end
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    endOfTest();
  end
endmodule : slmc_config_bench

/* File: verif/slmc_tx_model.sv */
// Sender-side sample source model for the configuration block bench
`timescale 1ns/1ps
module slmc_tx_model (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        start,
  input  wire logic [15:0] value,
  output logic      [15:0] sampleIn,
  output logic             sampleValid,
  output logic             busy
);
  // ----------------------------------------
  // Burst of three samples, sixteen cycles apart
  // ----------------------------------------
  // Wide spacing keeps the input rate under every upsample limit
  // Link parameters come from the bench setup, which mirrors the receive side
  logic [5:0] step;
  assign busy = (step != 6'h00);
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      step        <= 6'h00;
      sampleValid <= 1'b0;
      sampleIn    <= 16'h0000;
    end else begin
      if (start && !busy) begin
        step <= 6'h3f;
      end else if (busy) begin
        step <= step - 6'h01;
      end
      sampleValid <= busy && (step[3:0] == 4'h0);
      // Idle data is the inverse so a stale sample is never mistaken for new
      sampleIn    <= (busy && (step[3:0] == 4'h0)) ? value : ~value;
    end
  end
endmodule : slmc_tx_model
